// ===== ldfc_defs.vh
// Constants for the LED dimming and fault control block
`ifndef LDFC_DEFS_VH
`define LDFC_DEFS_VH
`define LDFC_NCH            4
`define LDFC_NARROW_MAX     8'd5
`define LDFC_WIDE_MIN       8'd6
`define LDFC_CNT_W          8
`define LDFC_CNT_SAT        8'hff
`define LDFC_SS_TIME_MS     100
`define LDFC_CLK_MHZ        100
`define LDFC_SS_CYCLES      (`LDFC_SS_TIME_MS * 1000 * `LDFC_CLK_MHZ)
`define LDFC_SS_W           24
`define LDFC_DETECT_CYCLES  16
`endif

// ===== ldfc_led_dimming_fault_control.v
// Sequencer, dimming gate, feedback mode and fault logic of the LED driver
`include "ldfc_defs.vh"

// Functional notes
// R1: Dimming off stops switching and isolates error amp from compensation.
// R2: On-pulse of four cycles or fewer selects overvoltage-sense feedback.
// R3: In narrow-pulse mode, amp stays connected and switching continues.
// R4: Enter OV feedback below 5 cycles; leave at 6 or more.
// R5: Operation starts only when both undervoltage monitors are good.
// R6: Enable low shuts everything down; nothing starts until enable high.
// R7: Detect and disconnect unused channels before soft-start.
// R8: Soft-start uses OV feedback; ends at min sink 1V, 95% OV, or timeout.
// R9: Min-sink-voltage end of soft-start only counts while dimming on.
// R10: After overvoltage, drop open strings, adaptive control at next pulse.
// R11: Dimming high enables all sinks together, low disables all.
// R12: Fault flag asserts on open, short or thermal shutdown.
// R13: Thermal and short faults self-clear; open fault latches.
// R14: Over-temperature shuts controller down until it clears.
// R15: Channels grounded at power-up are unused and never flag faults.
// R16: After soft-start, open strings leave the minimum detector.
// R17: Overvoltage stops switching, drive low, drops sinks below 300mV.
// R18: Each rising dimming edge samples per-channel short comparators; code samples them only in ST_RUN.
// R19: Shorted channel off, flag held until a later edge finds it gone.
// R20: Short threshold tied to regulator output disables short detection.
// R21: Pulse width counted; mode applies from next pulse, hysteresis held.
// R22: Enable low or undervoltage resets disconnects, latch and sequencer.
module ldfc_led_dimming_fault_control #(
  parameter SS_CYCLES = `LDFC_SS_CYCLES
) (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       enable_in,
  input  wire       vin_uv_ok,
  input  wire       vcc_uv_ok,
  input  wire       over_temp,
  input  wire       dimming_pwm_in,
  input  wire       overvoltage_sense_in,
  input  wire       ov_regulated_95,
  input  wire       min_sink_at_1v,
  input  wire [3:0] sink_ground,
  input  wire [3:0] sink_below_300mv,
  input  wire [3:0] short_cmp,
  input  wire       short_threshold_in,
  input  wire       pwm_cycle_on,
  input  wire       osc_tick,
  output reg  [3:0] sink_enable,
  output reg  [3:0] min_detect_mask,
  output reg        gate_drive_out,
  output reg        amp_connect,
  output reg        fb_ov_mode,
  output reg        fault_flag_n
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  wire       enS;
  wire       vinOk;
  wire       vccOk;
  wire       otS;
  wire       dimS;
  wire       ovS;
  wire       at95S;
  wire       at1vS;
  wire       sdisS;
  wire [3:0] gndS;
  wire       cycOnS;
  wire       tickS;
  wire [3:0] loS;
  wire [3:0] shS;

  // Supervisory levels: enable, both undervoltage monitors and over-temperature
  ldfc_sync #(.W(1)) u_ldfc_sync_en (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (enable_in),
    .q     (enS)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_vin (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (vin_uv_ok),
    .q     (vinOk)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_vcc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (vcc_uv_ok),
    .q     (vccOk)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_ot (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (over_temp),
    .q     (otS)
  );

  // Host dimming input and the oscillator as a level
  ldfc_sync #(.W(1)) u_ldfc_sync_dim (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (dimming_pwm_in),
    .q     (dimS)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (osc_tick),
    .q     (tickS)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_cyc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (pwm_cycle_on),
    .q     (cycOnS)
  );

  // Analog comparators settle on their own time, never on mclk
  ldfc_sync #(.W(1)) u_ldfc_sync_ov (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (overvoltage_sense_in),
    .q     (ovS)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_at95 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (ov_regulated_95),
    .q     (at95S)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_at1v (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (min_sink_at_1v),
    .q     (at1vS)
  );
  ldfc_sync #(.W(1)) u_ldfc_sync_sdis (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (short_threshold_in),
    .q     (sdisS)
  );
  // Each channel keeps its own bit so no grounded output is misread
  ldfc_sync #(.W(4)) u_ldfc_sync_gnd (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (sink_ground),
    .q     (gndS)
  );
  ldfc_sync #(.W(4)) u_ldfc_sync_lo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (sink_below_300mv),
    .q     (loS)
  );
  ldfc_sync #(.W(4)) u_ldfc_sync_sh (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (short_cmp),
    .q     (shS)
  );

  // Enable or either undervoltage monitor drops the whole block
  wire runOk = enS & vinOk & vccOk; // [R5] [R6]

  // ********************************************************************
  // Edge detection
  // ********************************************************************
  reg dimDlyReg;
  reg tickDlyReg;
  always @(posedge mclk) begin
    if (!rst_n) begin
      dimDlyReg  <= 1'b0;
      tickDlyReg <= 1'b0;
    end else begin
      dimDlyReg  <= dimS;
      tickDlyReg <= tickS;
    end
  end
  wire dimRise = dimS & ~dimDlyReg;
  wire dimFall = ~dimS & dimDlyReg;
  wire oscEdge = tickS & ~tickDlyReg;

  // ********************************************************************
  // Power-up sequencer
  // ********************************************************************
  localparam ST_OFF    = 4'b0001;
  localparam ST_DETECT = 4'b0010;
  localparam ST_SOFT   = 4'b0100;
  localparam ST_RUN    = 4'b1000;

  reg [3:0]             stateReg;
  reg [3:0]             stateNext;
  reg [`LDFC_SS_W-1:0]  ssCntReg;
  reg [4:0]             detCntReg;
  reg [3:0]             unusedReg;

  always @* begin
    stateNext = stateReg;
    case (stateReg)
      ST_OFF:    if (runOk) stateNext = ST_DETECT;
      ST_DETECT: if (detCntReg == `LDFC_DETECT_CYCLES)
                   stateNext = ST_SOFT; // [R7]
      ST_SOFT:   if ((at1vS & dimS) | at95S |
                     (ssCntReg == SS_CYCLES[`LDFC_SS_W-1:0]))
                   stateNext = ST_RUN; // [R8] [R9]
      ST_RUN:    stateNext = ST_RUN;
      default:   stateNext = ST_OFF;
    endcase
    if (!runOk)
      stateNext = ST_OFF; // [R22]
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      stateReg  <= ST_OFF;
      ssCntReg  <= {`LDFC_SS_W{1'b0}};
      detCntReg <= 5'd0;
      unusedReg <= 4'h0;
    end else begin
      stateReg <= stateNext;
      if (stateReg == ST_SOFT)
        ssCntReg <= ssCntReg + 1'b1;
      else
        ssCntReg <= {`LDFC_SS_W{1'b0}};
      if (stateReg == ST_DETECT)
        detCntReg <= detCntReg + 5'd1;
      else
        detCntReg <= 5'd0;
      // Grounded outputs captured while detecting, kept until shutdown
      if (stateReg == ST_OFF)
        unusedReg <= 4'h0; // [R22]
      else if (stateReg == ST_DETECT)
        unusedReg <= gndS; // [R15]
    end
  end

  // ********************************************************************
  // Pulse width measurement and feedback mode
  // ********************************************************************
  reg [`LDFC_CNT_W-1:0] widthReg;
  reg                   narrowReg;
  always @(posedge mclk) begin
    if (!rst_n || !runOk) begin
      widthReg   <= 8'h00;
      narrowReg  <= 1'b0;
      fb_ov_mode <= 1'b1;
    end else begin
      // Saturating count: a very long pulse must not wrap to narrow
      if (dimRise)
        widthReg <= 8'h00;
      else if (dimS && oscEdge && widthReg != `LDFC_CNT_SAT)
        widthReg <= widthReg + 8'h01; // [R21]
      // Between limits the previous choice is kept
      if (dimFall) begin
        if (widthReg < `LDFC_NARROW_MAX)
          narrowReg <= 1'b1; // [R4]
        else if (widthReg >= `LDFC_WIDE_MIN)
          narrowReg <= 1'b0; // [R4]
      end
      // Mode changes only at a pulse start, so a pulse never sees two loops
      if (stateReg != ST_RUN)
        fb_ov_mode <= 1'b1; // [R8]
      else if (dimRise) begin
        fb_ov_mode <= narrowReg; // [R2] [R10] [R21]
      end
    end
  end

  // ********************************************************************
  // Open and short string handling
  // ********************************************************************
  reg [3:0] openReg;
  reg [3:0] shortReg;
  reg       openLatchReg;
  always @(posedge mclk) begin
    if (!rst_n || !runOk) begin
      openReg      <= 4'h0; // [R22]
      shortReg     <= 4'h0;
      openLatchReg <= 1'b0;
    end else begin
      if (ovS && stateReg == ST_RUN) begin
        openReg <= openReg | (loS & ~unusedReg); // [R10] [R16] [R17]
        if (|(loS & ~unusedReg))
          openLatchReg <= 1'b1; // [R13]
      end
      if (sdisS)
        shortReg <= 4'h0; // [R20]
      else if (dimRise && stateReg == ST_RUN)
        shortReg <= shS & ~unusedReg; // [R18] [R19]
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  wire running = (stateReg == ST_SOFT) | (stateReg == ST_RUN);
  wire [3:0] live = ~unusedReg & ~openReg & ~shortReg;
  // Narrow-pulse mode keeps the loop alive so tiny pulses see a ready rail
  wire keepLoop = fb_ov_mode & (stateReg == ST_RUN); // [R3]
  wire swAllow  = running & ~otS & ~ovS & (dimS | keepLoop); // [R1] [R14]
  always @(posedge mclk) begin
    if (!rst_n) begin
      sink_enable     <= 4'h0;
      min_detect_mask <= 4'h0;
      gate_drive_out  <= 1'b0;
      amp_connect     <= 1'b0;
      fault_flag_n    <= 1'b1;
    end else begin
      sink_enable     <= (running & dimS & ~otS) ? live : 4'h0; // [R11]
      min_detect_mask <= live & ~(ovS ? loS : 4'h0); // [R16] [R17]
      gate_drive_out  <= swAllow & cycOnS; // [R17]
      amp_connect     <= running & (dimS | keepLoop); // [R1] [R3]
      // Open fault latches; short and thermal follow their sources
      fault_flag_n    <= ~(openLatchReg | (|shortReg) | otS); // [R12]
    end
  end

endmodule // ldfc_led_dimming_fault_control

// ********************************************************************
// Two-flop synchroniser
// ********************************************************************
module ldfc_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] metaReg;
  reg [W-1:0] syncReg;
  // Only syncReg may be read outside; metaReg can be metastable
  always @(posedge mclk) begin
    if (!rst_n) begin
      metaReg <= {W{1'b0}};
      syncReg <= {W{1'b0}};
    end else begin
      metaReg <= d;
      syncReg <= metaReg;
    end
  end
  assign q = syncReg;
endmodule // ldfc_sync

// ===== ldfc_partner.sv
// Model of the host dimming source, LED strings and power stage
module ldfc_partner (
  input  wire        mclk,
  input  wire  [7:0] onLen,
  input  wire  [3:0] openMask,
  output logic       dimOut = 1'b0,
  output logic       oscTick = 1'b0,
  output logic       ovSense = 1'b0,
  output logic [3:0] below300 = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  // A period of 100 cycles keeps every requested width inside it
  always @(posedge mclk) begin
    cnt <= (cnt == 8'd99) ? 8'h00 : cnt + 8'h01;
    dimOut <= cnt < onLen;
    oscTick <= cnt[1];
    // An open string pulls its sink low and drives the output to the limit
    ovSense <= |openMask;
    below300 <= openMask;
  end
endmodule // ldfc_partner

// ===== ldfc_props.sv
// Port checker for the LED dimming and fault control block
module ldfc_props (
  input wire       mclk,
  input wire       rst_n,
  input wire       enable_in,
  input wire       vin_uv_ok,
  input wire       vcc_uv_ok,
  input wire       over_temp,
  input wire       dimming_pwm_in,
  input wire       overvoltage_sense_in,
  input wire [3:0] sink_enable,
  input wire       gate_drive_out,
  input wire       amp_connect,
  input wire       fb_ov_mode,
  input wire       fault_flag_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Four cycles cover synchronisers and output register; shutdown
  // passes the state or fault registers as well and needs five
  sequence s_dim_off; !dimming_pwm_in [*4]; endsequence
  sequence s_calm; (!enable_in && !over_temp) [*5]; endsequence
  AST_EN_OFF: assert property (!enable_in [*5] |->
    sink_enable == 4'h0 && !gate_drive_out) else $error("enable off");
  AST_UV: assert property ((!vin_uv_ok || !vcc_uv_ok) [*5] |->
    sink_enable == 4'h0 && !gate_drive_out) else $error("undervoltage");
  AST_DIM_OFF: assert property (s_dim_off |-> sink_enable == 4'h0)
    else $error("dim off");
  AST_HOLD: assert property (s_dim_off ##0 !fb_ov_mode |->
    !amp_connect && !gate_drive_out) else $error("dim hold");
  AST_OVP: assert property (overvoltage_sense_in [*4] |->
    !gate_drive_out) else $error("ov drive");
  AST_HOT: assert property ((over_temp && enable_in) [*4] |->
    !fault_flag_n && !gate_drive_out) else $error("thermal");
  AST_CALM: assert property (s_calm |-> fault_flag_n)
    else $error("flag stuck");
  AST_DIM_ON: assert property ($rose(|sink_enable) |->
    $past(dimming_pwm_in, 3)) else $error("sink early");
endmodule // ldfc_props

bind ldfc_led_dimming_fault_control ldfc_props u_ldfc_props (.*);

// ===== tb_led_dimming_fault_control.sv
// Self-checking bench for the LED dimming and fault control block
`define CHK(o, e) begin checks_done++; if ((o) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, o, e); end end
module tb_led_dimming_fault_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0, rst_n = 1'b0, enable_in = 1'b0, over_temp = 1'b0;
  logic        vin_uv_ok = 1'b1, vcc_uv_ok = 1'b1, short_threshold_in = 1'b0;
  logic        chkReq = 1'b0;
  logic  [3:0] sink_ground = 4'h3, short_cmp = 4'h0, openMask = 4'h0;
  logic  [7:0] onLen = 8'h00, lfsr = 8'h56;
  logic [15:0] expQ[$];
  int          num_errors = 0, checks_done = 0;
  wire         dimming_pwm_in, osc_tick, overvoltage_sense_in;
  wire   [3:0] sink_below_300mv, sink_enable, min_detect_mask;
  wire         gate_drive_out, amp_connect, fb_ov_mode, fault_flag_n;
  wire         ov_regulated_95 = 1'b0;
  wire         min_sink_at_1v = dimming_pwm_in;
  wire         pwm_cycle_on = osc_tick;
  wire   [7:0] obs = {fault_flag_n, fb_ov_mode, gate_drive_out, 1'b0,
                      sink_enable};
  always #5 mclk = ~mclk;
  ldfc_led_dimming_fault_control #(.SS_CYCLES(50))
    u_ldfc_led_dimming_fault_control (.*);
  ldfc_partner u_ldfc_partner (.mclk(mclk), .onLen(onLen),
    .openMask(openMask), .dimOut(dimming_pwm_in), .oscTick(osc_tick),
    .ovSense(overvoltage_sense_in), .below300(sink_below_300mv));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Two edges per note, so back-to-back notes never collide on the strobe
  task automatic expect_obs(input logic [7:0] m, input logic [7:0] v);
    expQ.push_back({m, v});
    chkReq <= 1'b1;
    @(posedge mclk);
    chkReq <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_dim(input logic lvl);
    int i;
    for (i = 0; i < 1000 && dimming_pwm_in !== lvl; i++) @(posedge mclk);
    if (i == 1000) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) if (chkReq) begin : mon
    logic [15:0] e;
    e = expQ.pop_front();
    `CHK(obs & e[15:8], e[7:0])
  end
  initial begin
    wait_cyc(4);
    rst_n <= 1'b1;
    wait_cyc(4);
    expect_obs(8'hcf, 8'hc0);
    $display("reset test done");
    enable_in <= 1'b1;
    onLen <= 8'd60;
    wait_cyc(600);
    wait_dim(1'b1);
    wait_cyc(8);
    expect_obs(8'hcf, 8'h8c);
    wait_dim(1'b0);
    wait_cyc(6);
    expect_obs(8'h0f, 8'h00);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      onLen <= 8'd4 + {5'h0, lfsr[2:0]};
      wait_cyc(300);
      expect_obs(8'h40, 8'h40);
      onLen <= 8'd40 + {3'h0, lfsr[4:0]};
      wait_cyc(300);
      expect_obs(8'h40, 8'h00);
    end
    $display("dimming test done");
    short_cmp <= 4'h4;
    wait_cyc(250);
    wait_dim(1'b1);
    wait_cyc(8);
    expect_obs(8'h8c, 8'h08);
    short_cmp <= 4'h0;
    wait_cyc(250);
    expect_obs(8'h80, 8'h80);
    short_threshold_in <= 1'b1;
    short_cmp <= 4'h4;
    wait_cyc(250);
    expect_obs(8'h80, 8'h80);
    short_cmp <= 4'h0;
    short_threshold_in <= 1'b0;
    $display("short test done");
    over_temp <= 1'b1;
    wait_cyc(10);
    expect_obs(8'ha0, 8'h00);
    over_temp <= 1'b0;
    wait_cyc(10);
    expect_obs(8'h80, 8'h80);
    $display("thermal test done");
    openMask <= 4'h8;
    wait_cyc(250);
    openMask <= 4'h0;
    wait_cyc(250);
    expect_obs(8'h80, 8'h00);
    enable_in <= 1'b0;
    vin_uv_ok <= 1'b0;
    wait_cyc(10);
    expect_obs(8'ha0, 8'h80);
    enable_in <= 1'b1;
    vin_uv_ok <= 1'b1;
    wait_cyc(600);
    expect_obs(8'h80, 8'h80);
    $display("open test done");
    conclude();
  end
endmodule // tb_led_dimming_fault_control
